// file: auc_core.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module auc_core
  import auc_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transmit_clock_pin_i,
  output var auc_pin_out_t transmit_clock_pin,
  input wire logic receive_data_pin_i,
  output var auc_pin_out_t receive_data_pin
);

  if (DIV_W < 1 || DIV_W > 8 || ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("auc_core: DIV_W must be 1..8 and ADDR_W 5..8");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return {a[ADDR_W-1:2], 2'b00} == ofs[ADDR_W-1:0];
  endfunction : hit

  auc_txcs_t txcs_reg;
  auc_rxcs_t rxcs_reg;
  auc_txcs_t txcs_view;
  logic [DIV_W-1:0] div_reg;
  logic [7:0] tx_hold_reg;
  logic tx_hold_full_reg;
  logic [7:0] rx_buf_reg;
  logic rx_full_reg;

  // AXI4-Lite slave
  logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic w_lane0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_fire, wr_en, ar_fire;
  logic w_txcs, w_rxcs, w_div, w_txd, rd_rxbuf, wr_mapped, rd_mapped;
  logic [31:0] rd_val;

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_en = wr_fire && w_lane0_reg;
  assign ar_fire = s_axi_arvalid && !rvalid_reg;
  assign w_txcs = wr_en && hit(aw_addr_reg, AUC_TXCS_OFS);
  assign w_rxcs = wr_en && hit(aw_addr_reg, AUC_RXCS_OFS);
  assign w_div = wr_en && hit(aw_addr_reg, AUC_DIV_OFS);
  assign w_txd = wr_en && hit(aw_addr_reg, AUC_TXDATA_OFS);
  assign rd_rxbuf = ar_fire && hit(s_axi_araddr, AUC_RXBUF_OFS);
  assign wr_mapped = hit(aw_addr_reg, AUC_TXCS_OFS) || hit(aw_addr_reg, AUC_RXCS_OFS) ||
                     hit(aw_addr_reg, AUC_DIV_OFS) || hit(aw_addr_reg, AUC_TXDATA_OFS) ||
                     hit(aw_addr_reg, AUC_RXBUF_OFS) || hit(aw_addr_reg, AUC_STAT_OFS);
  assign rd_mapped = hit(s_axi_araddr, AUC_TXCS_OFS) || hit(s_axi_araddr, AUC_RXCS_OFS) ||
                     hit(s_axi_araddr, AUC_DIV_OFS) || hit(s_axi_araddr, AUC_TXDATA_OFS) ||
                     hit(s_axi_araddr, AUC_RXBUF_OFS) || hit(s_axi_araddr, AUC_STAT_OFS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AUC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? AUC_RESP_OKAY : AUC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Mode decode
  logic en, sync_m, master, sync_rx_req, tx_allowed;
  assign en = rxcs_reg.port_enable;
  assign sync_m = txcs_reg.sync_mode;
  assign master = sync_m && txcs_reg.clock_source_select;
  assign sync_rx_req = sync_m && en && (rxcs_reg.continuous_receive_enable ||
                       (master && rxcs_reg.single_receive_enable));
  assign tx_allowed = en && txcs_reg.transmit_enable && !sync_rx_req;

  // Baud timer
  logic [DIV_W-1:0] brg_cnt_reg;
  logic [1:0] pre_reg;
  logic brg_tick, os_tick, half_tick;
  assign brg_tick = brg_cnt_reg == div_reg;
  assign os_tick = brg_tick && (txcs_reg.high_speed_select || pre_reg == AUC_LOW_PRE_LAST);
  assign half_tick = brg_tick && pre_reg[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brg_cnt_reg <= '0;
      pre_reg <= 2'h0;
    end else if (w_div) begin
      brg_cnt_reg <= '0;
      pre_reg <= 2'h0;
    end else begin
      brg_cnt_reg <= brg_tick ? '0 : brg_cnt_reg + 1'b1;
      pre_reg <= brg_tick ? pre_reg + 2'h1 : pre_reg;
    end
  end

  // Synchronous clock events
  logic sclk_reg, sclk_prev_reg, sync_busy, rise_evt, fall_evt;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_left_reg, tx_os_reg;
  logic tx_active, tx_load, sync_rx_run;
  assign tx_active = tx_left_reg != 4'h0;
  assign sync_busy = en && ((tx_active && sync_m) || sync_rx_req || sclk_reg);
  assign rise_evt = master ? (half_tick && sync_busy && !sclk_reg) :
                    (sync_m && transmit_clock_pin_i && !sclk_prev_reg);
  assign fall_evt = master ? (half_tick && sync_busy && sclk_reg) :
                    (sync_m && !transmit_clock_pin_i && sclk_prev_reg);
  assign sync_rx_run = sync_rx_req;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= transmit_clock_pin_i;
      if (!master || !en) begin
        sclk_reg <= 1'b0;
      end else if (half_tick && sync_busy) begin
        sclk_reg <= !sclk_reg;
      end
    end
  end

  // Transmitter
  assign tx_load = tx_allowed && tx_hold_full_reg && !tx_active;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= 11'h7ff;
      tx_left_reg <= 4'h0;
      tx_os_reg <= 4'h0;
    end else if (!en) begin
      tx_left_reg <= 4'h0;
    end else if (tx_load) begin
      tx_os_reg <= 4'h0;
      if (sync_m) begin
        tx_sh_reg <= {2'b00, txcs_reg.transmit_ninth_bit, tx_hold_reg};
        tx_left_reg <= txcs_reg.transmit_nine_bit_select ? AUC_SYNC_BITS9 : AUC_SYNC_BITS8;
      end else begin
        tx_sh_reg <= {1'b1, txcs_reg.transmit_nine_bit_select ? txcs_reg.transmit_ninth_bit :
                      1'b1, tx_hold_reg, 1'b0};
        tx_left_reg <= txcs_reg.transmit_nine_bit_select ? AUC_ASYNC_BITS9 :
                       AUC_ASYNC_BITS8;
      end
    end else if (tx_active && !sync_m && os_tick) begin
      tx_os_reg <= tx_os_reg + 4'h1;
      if (tx_os_reg == AUC_OS_LAST) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end else if (tx_active && sync_m && !sync_rx_req) begin
      // Count bits on the fall so data holds past the last rise
      if (fall_evt) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  // Receivers
  auc_rx_state_t rx_state_reg;
  logic [3:0] rx_os_reg, rx_idx_reg, rx_last;
  logic [1:0] rx_samp_reg;
  logic [8:0] rx_sh_reg, rx_word;
  logic rx_vote, async_done, sync_done, char_done, accept, ovr_set;
  assign rx_last = rxcs_reg.receive_nine_bit_select ? 4'h9 : 4'h8;
  assign rx_vote = auc_majority(rx_samp_reg[1], rx_samp_reg[0], receive_data_pin_i);
  assign async_done = rx_state_reg == AUC_RX_BITS && os_tick && rx_os_reg == AUC_VOTE_C &&
                      rx_idx_reg == rx_last;
  assign sync_done = sync_rx_run && rise_evt && rx_idx_reg == rx_last - 4'h1;
  assign char_done = async_done || sync_done;
  always_comb begin
    rx_word = rx_sh_reg;
    if (sync_done) begin
      rx_word[rx_idx_reg] = receive_data_pin_i;
    end
    if (!rxcs_reg.receive_nine_bit_select) begin
      rx_word[8] = 1'b0;
    end
  end
  assign accept = char_done && !(!sync_m && rxcs_reg.receive_nine_bit_select &&
                  rxcs_reg.address_detect_enable && !rx_word[8]);
  assign ovr_set = accept && rx_full_reg && !rd_rxbuf;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= AUC_RX_IDLE;
      rx_os_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_samp_reg <= 2'b11;
      rx_sh_reg <= 9'h0;
    end else if (sync_m) begin
      rx_state_reg <= AUC_RX_IDLE;
      if (!sync_rx_run) begin
        rx_idx_reg <= 4'h0;
      end else if (rise_evt) begin
        rx_sh_reg[rx_idx_reg] <= receive_data_pin_i;
        rx_idx_reg <= sync_done ? 4'h0 : rx_idx_reg + 4'h1;
      end
    end else if (!en || !rxcs_reg.continuous_receive_enable) begin
      rx_state_reg <= AUC_RX_IDLE;
    end else begin
      case (rx_state_reg)
        AUC_RX_IDLE: begin
          rx_os_reg <= 4'h0;
          rx_idx_reg <= 4'h0;
          if (!receive_data_pin_i) begin
            rx_state_reg <= AUC_RX_START;
            rx_sh_reg <= 9'h0;
          end
        end
        AUC_RX_START, AUC_RX_BITS: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == AUC_VOTE_A || rx_os_reg == AUC_VOTE_B) begin
              rx_samp_reg <= {rx_samp_reg[0], receive_data_pin_i};
            end
            if (rx_os_reg == AUC_VOTE_C) begin
              if (rx_state_reg == AUC_RX_START) begin
                if (rx_vote) begin
                  rx_state_reg <= AUC_RX_IDLE;
                end
              end else if (rx_idx_reg == rx_last) begin
                rx_state_reg <= AUC_RX_IDLE;
              end else begin
                rx_sh_reg[rx_idx_reg] <= rx_vote;
                rx_idx_reg <= rx_idx_reg + 4'h1;
              end
            end
            if (rx_os_reg == AUC_OS_LAST) begin
              rx_state_reg <= AUC_RX_BITS;
            end
          end
        end
        default: rx_state_reg <= AUC_RX_IDLE;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txcs_reg <= AUC_TXCS_RST;
      div_reg <= AUC_DIV_RST[DIV_W-1:0];
      tx_hold_reg <= 8'h0;
      tx_hold_full_reg <= 1'b0;
    end else begin
      if (w_txcs) begin
        txcs_reg <= (w_data_reg[7:0] & AUC_TXCS_WMASK) | (txcs_reg & ~AUC_TXCS_WMASK);
      end
      if (w_div) begin
        div_reg <= w_data_reg[DIV_W-1:0];
      end
      if (w_txd) begin
        tx_hold_reg <= w_data_reg[7:0];
        tx_hold_full_reg <= 1'b1;
      end else if (tx_load) begin
        tx_hold_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxcs_reg <= AUC_RXCS_RST;
      rx_buf_reg <= 8'h0;
      rx_full_reg <= 1'b0;
    end else begin
      if (w_rxcs) begin
        rxcs_reg <= (w_data_reg[7:0] & AUC_RXCS_WMASK) | (rxcs_reg & ~AUC_RXCS_WMASK);
      end else if (sync_done && master && !rxcs_reg.continuous_receive_enable) begin
        rxcs_reg.single_receive_enable <= 1'b0;
      end
      if (accept && !ovr_set) begin
        rx_buf_reg <= rx_word[7:0];
        rx_full_reg <= 1'b1;
        rxcs_reg.received_ninth_bit <= rx_word[8];
        rxcs_reg.framing_error <= async_done && !rx_vote;
      end else if (rd_rxbuf) begin
        rx_full_reg <= 1'b0;
      end
      if (ovr_set) begin
        rxcs_reg.overrun_error <= 1'b1;
      end else if (!rxcs_reg.continuous_receive_enable) begin
        rxcs_reg.overrun_error <= 1'b0;
      end
    end
  end

  // Read path
  always_comb begin
    txcs_view = txcs_reg;
    txcs_view.unused3 = 1'b0;
    txcs_view.shifter_empty = !tx_active;
    rd_val = 32'h0;
    if (hit(s_axi_araddr, AUC_TXCS_OFS)) begin
      rd_val[7:0] = txcs_view;
    end else if (hit(s_axi_araddr, AUC_RXCS_OFS)) begin
      rd_val[7:0] = rxcs_reg;
    end else if (hit(s_axi_araddr, AUC_DIV_OFS)) begin
      rd_val[DIV_W-1:0] = div_reg;
    end else if (hit(s_axi_araddr, AUC_TXDATA_OFS)) begin
      rd_val[7:0] = tx_hold_reg;
    end else if (hit(s_axi_araddr, AUC_RXBUF_OFS)) begin
      rd_val[7:0] = rx_buf_reg;
    end else if (hit(s_axi_araddr, AUC_STAT_OFS)) begin
      rd_val[1:0] = {tx_hold_full_reg, rx_full_reg};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= AUC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_mapped ? AUC_RESP_OKAY : AUC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_clock_pin <= 2'b11;
      receive_data_pin <= 2'b11;
    end else begin
      transmit_clock_pin.oe_n <= !en || (sync_m && !master);
      transmit_clock_pin.o <= sync_m ? sclk_reg : (!tx_active || tx_sh_reg[0]);
      receive_data_pin.oe_n <= !(en && sync_m && tx_active && !sync_rx_req);
      receive_data_pin.o <= tx_sh_reg[0];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_async_load;
    tx_load && !sync_m;
  endsequence

  logic rd_txcs_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_txcs_reg <= 1'b0;
    end else begin
      rd_txcs_reg <= ar_fire && hit(s_axi_araddr, AUC_TXCS_OFS);
    end
  end

  baud_clear_a: assert property (w_div |=> brg_cnt_reg == '0 ##1 !w_div || brg_tick || brg_cnt_reg == DIV_W'(1)) else $error("baud timer not cleared");
  low_prescale_a: assert property (os_tick && !txcs_reg.high_speed_select |-> pre_reg == AUC_LOW_PRE_LAST) else $error("low speed prescale wrong");
  unused_zero_a: assert property (rd_txcs_reg |-> s_axi_rvalid && s_axi_rdata[3] == 1'b0) else $error("unused bit not zero");
  empty_flag_a: assert property (tx_load |=> !txcs_view.shifter_empty) else $error("shifter empty after load");
  rx_override_a: assert property (sync_m && sync_rx_req |-> !tx_load) else $error("transmit during sync receive");
  nine_frame_a: assert property (s_async_load ##0 txcs_reg.transmit_nine_bit_select |=> tx_left_reg == AUC_ASYNC_BITS9 && tx_sh_reg[9] == $past(txcs_reg.transmit_ninth_bit) && tx_sh_reg[0] == 1'b0) else $error("nine bit frame wrong");
  addr_skip_a: assert property (char_done && !sync_m && rxcs_reg.receive_nine_bit_select && rxcs_reg.address_detect_enable && !rx_word[8] |=> $stable(rx_buf_reg)) else $error("address detect loaded data");
  ovr_clear_a: assert property (!rxcs_reg.continuous_receive_enable && !ovr_set |=> !rxcs_reg.overrun_error) else $error("overrun not cleared");
  single_clear_a: assert property (sync_done && master && !rxcs_reg.continuous_receive_enable && !w_rxcs |=> !rxcs_reg.single_receive_enable) else $error("single receive not cleared");
  pins_off_a: assert property (!en |=> transmit_clock_pin.oe_n && receive_data_pin.oe_n) else $error("pins driven while disabled");
  sync_clk_a: assert property (master && en && half_tick && sync_busy |=> sclk_reg != $past(sclk_reg)) else $error("master clock missed toggle");
  frame_err_a: assert property (async_done && accept && !ovr_set |=> rxcs_reg.framing_error == !$past(rx_vote)) else $error("framing error wrong");

endmodule : auc_core
`default_nettype wire

// file: auc_pkg.sv
`default_nettype none
package auc_pkg;
  // Register byte offsets
  localparam logic [7:0] AUC_TXCS_OFS = 8'h00;
  localparam logic [7:0] AUC_RXCS_OFS = 8'h04;
  localparam logic [7:0] AUC_DIV_OFS = 8'h08;
  localparam logic [7:0] AUC_TXDATA_OFS = 8'h0c;
  localparam logic [7:0] AUC_RXBUF_OFS = 8'h10;
  localparam logic [7:0] AUC_STAT_OFS = 8'h14;
  // Reset values and writable masks
  localparam logic [7:0] AUC_TXCS_RST = 8'h02;
  localparam logic [7:0] AUC_RXCS_RST = 8'h00;
  localparam logic [7:0] AUC_DIV_RST = 8'h00;
  localparam logic [7:0] AUC_TXCS_WMASK = 8'hf5;
  localparam logic [7:0] AUC_RXCS_WMASK = 8'hf8;
  // Bit timing
  localparam logic [3:0] AUC_OS_LAST = 4'hf;
  localparam logic [1:0] AUC_LOW_PRE_LAST = 2'h3;
  localparam logic [3:0] AUC_VOTE_A = 4'h7;
  localparam logic [3:0] AUC_VOTE_B = 4'h8;
  localparam logic [3:0] AUC_VOTE_C = 4'h9;
  localparam logic [3:0] AUC_ASYNC_BITS8 = 4'ha;
  localparam logic [3:0] AUC_ASYNC_BITS9 = 4'hb;
  localparam logic [3:0] AUC_SYNC_BITS8 = 4'h8;
  localparam logic [3:0] AUC_SYNC_BITS9 = 4'h9;
  // AXI responses
  localparam logic [1:0] AUC_RESP_OKAY = 2'b00;
  localparam logic [1:0] AUC_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic clock_source_select;
    logic transmit_nine_bit_select;
    logic transmit_enable;
    logic sync_mode;
    logic unused3;
    logic high_speed_select;
    logic shifter_empty;
    logic transmit_ninth_bit;
  } auc_txcs_t;

  typedef struct packed {
    logic port_enable;
    logic receive_nine_bit_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error;
    logic overrun_error;
    logic received_ninth_bit;
  } auc_rxcs_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } auc_pin_out_t;

  typedef enum logic [1:0] {AUC_RX_IDLE, AUC_RX_START, AUC_RX_BITS} auc_rx_state_t;

  function automatic logic auc_majority(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : auc_majority
endpackage : auc_pkg
`default_nettype wire

// file: auc_peer.sv
`timescale 1ns/1ns
`default_nettype none
module auc_peer (
  input wire logic line_in,
  output logic line_out
);
  // Line idles high between frames
  initial line_out = 1'b1;

  task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stp);
    line_out <= 1'b0;
    #(bt);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      #(bt);
    end
    line_out <= stp;
    #(bt);
    line_out <= 1'b1;
    #(bt);
  endtask : send

  task automatic sync_send(input logic [7:0] d);
    line_out <= d[0];
    for (int i = 1; i < 8; i++) begin
      @(negedge line_in);
      line_out <= d[i];
    end
    @(negedge line_in);
    line_out <= 1'b1;
  endtask : sync_send

  task automatic recv(input int nb, input int bt, output logic [8:0] d, output logic stp);
    d = 9'h000;
    @(negedge line_in);
    #(bt / 2);
    for (int i = 0; i < nb; i++) begin
      #(bt);
      d[i] = line_in;
    end
    #(bt);
    stp = line_in;
  endtask : recv
endmodule : auc_peer
`default_nettype wire

// file: addressable_usart_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module addressable_usart_core_tb_top;
  import auc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] wr_resp = 2'b00;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  auc_pin_out_t tx_pin, rx_pin;
  logic tx_i, rx_i, peer_line;
  int mismatches = 0;
  int n_tests = 0;

  always #50 clk = ~clk;
  // Pins resolve to the pull-up or the peer when released
  assign tx_i = tx_pin.oe_n ? 1'b1 : tx_pin.o;
  assign rx_i = rx_pin.oe_n ? peer_line : rx_pin.o;

  auc_core dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transmit_clock_pin_i(tx_i), .transmit_clock_pin(tx_pin),
    .receive_data_pin_i(rx_i), .receive_data_pin(rx_pin));
  auc_peer peer (.line_in(tx_i), .line_out(peer_line));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      wr_resp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, m);
    chk({30'h0, r}, {30'h0, AUC_RESP_OKAY}, m);
  endtask : rchk

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk(AUC_TXCS_OFS, 32'h02, "txcs rst");
    rchk(AUC_RXCS_OFS, 32'h00, "rxcs rst");
    rchk(AUC_DIV_OFS, 32'h00, "div rst");
    rd(8'h18, d, r);
    chk({30'h0, r}, {30'h0, AUC_RESP_SLVERR}, "unmapped");
    chk(d, 32'h0, "unmapped data");
    wr(8'h18, 8'h5a);
    chk({30'h0, wr_resp}, {30'h0, AUC_RESP_SLVERR}, "unmapped wr");
    wstrb <= 4'h0;
    wr(AUC_DIV_OFS, 8'h55);
    wstrb <= 4'hf;
    chk({30'h0, wr_resp}, {30'h0, AUC_RESP_OKAY}, "strobe off resp");
    rchk(AUC_DIV_OFS, 32'h00, "strobe off");
    wr(AUC_TXCS_OFS, 8'hff);
    rchk(AUC_TXCS_OFS, 32'hf7, "txcs bit3");
    wr(AUC_TXCS_OFS, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_tx();
    logic [7:0] cs [3];
    logic [7:0] dv [3];
    logic [8:0] dat [3];
    logic [8:0] got;
    logic stp;
    int b;
    cs = '{8'h24, 8'h20, 8'h65};
    dv = '{8'h00, 8'h01, 8'h00};
    dat = '{9'h0a5, 9'h03c, 9'h1c3};
    wr(AUC_RXCS_OFS, 8'h80);
    for (int i = 0; i < 3; i++) begin
      b = (cs[i][2] ? 16 : 64) * (dv[i] + 1) * 100;
      wr(AUC_DIV_OFS, dv[i]);
      wr(AUC_TXCS_OFS, cs[i]);
      fork
        peer.recv(cs[i][6] ? 9 : 8, b, got, stp);
        wr(AUC_TXDATA_OFS, dat[i][7:0]);
      join
      chk({23'h0, got}, {23'h0, dat[i]}, "tx data");
      chk({31'h0, stp}, 32'h1, "tx stop");
      #(b);
      rchk(AUC_TXCS_OFS, {24'h0, cs[i] | 8'h02}, "tx idle");
    end
    $display("transmit test done");
  endtask : t_tx

  task automatic t_rx();
    wr(AUC_TXCS_OFS, 8'h04);
    wr(AUC_DIV_OFS, 8'h00);
    wr(AUC_RXCS_OFS, 8'h90);
    peer.send(9'h05a, 8, 1600, 1'b1);
    rchk(AUC_STAT_OFS, 32'h1, "rx full");
    rchk(AUC_RXCS_OFS, 32'h90, "no framing_error");
    rchk(AUC_RXBUF_OFS, 32'h5a, "rx data");
    peer.send(9'h033, 8, 1600, 1'b0);
    rchk(AUC_RXCS_OFS, 32'h94, "framing_error");
    rchk(AUC_RXBUF_OFS, 32'h33, "framing_error data");
    peer.send(9'h011, 8, 1600, 1'b1);
    peer.send(9'h022, 8, 1600, 1'b1);
    rchk(AUC_RXCS_OFS, 32'h92, "overrun");
    wr(AUC_RXCS_OFS, 8'h80);
    rchk(AUC_RXCS_OFS, 32'h80, "overrun clr");
    rchk(AUC_RXBUF_OFS, 32'h11, "kept");
    wr(AUC_RXCS_OFS, 8'hd8);
    peer.send(9'h0a5, 9, 1600, 1'b1);
    rchk(AUC_STAT_OFS, 32'h0, "addr skip");
    peer.send(9'h1c3, 9, 1600, 1'b1);
    rchk(AUC_RXCS_OFS, 32'hd9, "ninth");
    rchk(AUC_RXBUF_OFS, 32'hc3, "addr data");
    $display("receive test done");
  endtask : t_rx

  task automatic t_sync();
    logic [7:0] d;
    time t0;
    time per;
    wr(AUC_RXCS_OFS, 8'h80);
    wr(AUC_TXCS_OFS, 8'hb0);
    fork
      for (int i = 0; i < 8; i++) begin
        @(posedge tx_pin.o);
        if (i == 1) per = $time - t0;
        t0 = $time;
        d[i] = rx_pin.o;
        chk({31'h0, rx_pin.oe_n}, 32'h0, "dt driven");
      end
      wr(AUC_TXDATA_OFS, 8'h96);
    join
    chk({24'h0, d}, 32'h96, "sync data");
    chk(32'(per), 32'(4 * (0 + 1) * 100), "sync period");
    $display("sync test done");
  endtask : t_sync

  task automatic t_srx();
    wait (!tx_pin.o && rx_pin.oe_n);
    fork
      peer.sync_send(8'h6b);
      wr(AUC_RXCS_OFS, 8'ha0);
    join
    rchk(AUC_RXCS_OFS, 32'h80, "single clr");
    rchk(AUC_RXBUF_OFS, 32'h6b, "sync rx data");
    $display("sync receive test done");
  endtask : t_srx

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_sync();
    t_srx();
    results();
  end

  initial begin
    #5000000;
    mismatches++;
    $display("[FAIL] %0t watchdog", $time);
    results();
  end
endmodule : addressable_usart_core_tb_top
`default_nettype wire
